// [src/csb_pkg.sv]
/*
  Shared constants and types for the card-side model of the socket bus.
  Assumes a single 10 MHz system clock and a slower card bus clock that is sampled.
*/
// ==========================================================================
// Package
package csb_pkg;
  // Widths of the 32-bit card bus and 16-bit card address; buffer depth
  localparam int unsigned AD_W       = 32;
  localparam int unsigned BE_W       = 4;
  localparam int unsigned WORD_W     = AD_W + BE_W;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned ADDR16_W   = 16;
  // Bus commands carried on the command lines in the address phase
  localparam logic [3:0] CMD_IO_RD  = 4'h2;
  localparam logic [3:0] CMD_IO_WR  = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  // Default decode windows
  localparam logic [31:0] MEM_BASE_DEF = 32'h1000_0000;
  localparam logic [31:0] MEM_MASK_DEF = 32'hFFFF_F000;
  localparam logic [31:0] IO_BASE_DEF  = 32'h0000_0300;
  localparam logic [31:0] IO_MASK_DEF  = 32'hFFFF_FFF0;
  localparam logic [15:0] IO16_BASE_DEF = 16'h0300;
  localparam logic [15:0] IO16_MASK_DEF = 16'hFFF0;
  // Synchroniser bundle: 10 control pins, command, address/data, 16-bit address
  localparam int unsigned SYNC_W = 10 + WORD_W + ADDR16_W;
  // Idle levels: clock low, card reset asserted, active-low lines high
  localparam logic [SYNC_W-1:0] SYNC_RST = {10'h0DF, {(WORD_W + ADDR16_W){1'b0}}};
  // Target sequencer, Gray along idle -> data -> turn
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01,
    ST_TURN = 2'b11,
    ST_SKIP = 2'b10
  } csb_state_t;
endpackage : csb_pkg

// [src/csb_stream_if.sv]
/*
  Valid/ready stream carrier between the card logic and its write buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
// ==========================================================================
// Stream interface
interface csb_stream_if #(parameter int unsigned W = 36);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : csb_stream_if

// [src/csb_sync.sv]
/*
  Three-stage synchroniser for a bundle of pins; a bit changes once stages two
  and three agree. Assumes the inputs are asynchronous to ref_clk_in.
*/
`timescale 1ns/1ps
// ==========================================================================
// Synchroniser
module csb_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         ref_clk_in,
  input  wire logic         sys_rst_in,
  // Pins and result
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree;

  // Only stage two and three are compared; stage one feeds stage two alone
  assign agree = ~(s2_q ^ s3_q);

  // Shift chain and glitch filter
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      s1_q     <= RST_VAL;
      s2_q     <= RST_VAL;
      s3_q     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      s1_q     <= async_in;
      s2_q     <= s1_q;
      s3_q     <= s2_q;
      sync_out <= (s2_q & agree) | (sync_out & ~agree);
    end
  end
endmodule : csb_sync

// [src/csb_fifo.sv]
/*
  Write-data buffer with parameterised width and depth.
  Assumes one clock; the drain side may stall to let it fill.
*/
`timescale 1ns/1ps
// ==========================================================================
// FIFO
module csb_fifo #(
  parameter int unsigned W     = 36,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input  wire logic     ref_clk_in,
  input  wire logic     sys_rst_in,
  // Fill and drain sides
  csb_stream_if.snk     push_if,
  csb_stream_if.src     pop_if
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0]   count_q;
  logic          do_push;
  logic          do_pop;

  // Honest flags straight from the occupancy count
  assign push_if.ready = (count_q != FULL_CNT);
  assign pop_if.valid  = (count_q != '0);
  assign pop_if.data   = mem[rd_ptr_q];
  assign do_push       = push_if.valid & push_if.ready;
  assign do_pop        = pop_if.valid & pop_if.ready;

  // Storage, written only on an accepted push
  always_ff @(posedge ref_clk_in) begin
    if (do_push) begin
      mem[wr_ptr_q] <= push_if.data;
    end
  end

  // Pointers and count
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (PW + 1)'(do_push) - (PW + 1)'(do_pop);
    end
  end
endmodule : csb_fifo

// [src/csb_card.sv]
/*
  Card end of the socket bus: a 16-bit card's status lines and a 32-bit bus
  target with a buffered write path. Assumes the socket controller makes the
  card bus clock and reset; both are sampled by ref_clk_in.
*/
// Contract
// RQ1: Memory mode: card-ready line low while busy, high when new command accepted.
// RQ2: I/O mode: same line is the interrupt request, high when none requested.
// RQ3: Controller keeps attribute select high for common memory accesses.
// RQ4: Controller uses attribute select as DMA acknowledge with I/O strobes.
// RQ5: Controller marks terminal count on DMA read with memory write strobe.
// RQ6: Card may assert wait; cycle is not completed while wait is asserted.
// RQ7: Wide-port indication only for a responding address on a 16-bit port.
// RQ8: Address phase is first frame clock; memory dword, I/O byte address.
// RQ9: Low data bits hold least significant byte, high bits most significant.
// RQ10: Word moves only when initiator ready and target ready are both asserted.
// RQ11: Command lines carry command in address phase, lane enables in data.
// RQ12: Parity is even over address/data and command/byte-enable lines.
// RQ13: Parity lags the bus one clock and stays one clock past completion.
// RQ14: Initiator drives address and write parity; target drives read parity.
// RQ15: Controller makes the bus clock; signals sampled on its rising edge.
// RQ16: Card requests faster clock on clock-run; controller signals slowdown there.
// RQ17: Controller releases bus reset synchronously to a bus clock edge.
// RQ18: While bus reset is asserted every card bus signal is high impedance; interrupt, status change and audio outputs stay driven.
// RQ19: Controller forwards binary card audio to the speaker output.
// RQ20: Controller asserts device select once it claims an access.
// RQ21: Frame asserted starts a transaction; frame released marks final data phase.
// RQ22: Controller grants the bus only after the current transaction completes.
// RQ23: Controller marks terminal count on DMA write with output enable.
// RQ24: In DMA, I/O read strobe writes memory and I/O write strobe reads it.
// RQ25: Asynchronous card inputs pass synchronisers before use.
`timescale 1ns/1ps
// ==========================================================================
// Card top
module csb_card #(
  parameter logic [31:0] MEM_BASE  = csb_pkg::MEM_BASE_DEF,
  parameter logic [31:0] MEM_MASK  = csb_pkg::MEM_MASK_DEF,
  parameter logic [31:0] IO_BASE   = csb_pkg::IO_BASE_DEF,
  parameter logic [31:0] IO_MASK   = csb_pkg::IO_MASK_DEF,
  parameter logic [15:0] IO16_BASE = csb_pkg::IO16_BASE_DEF,
  parameter logic [15:0] IO16_MASK = csb_pkg::IO16_MASK_DEF,
  parameter bit          WIDE_PORT = 1'b1,
  parameter int unsigned DEPTH     = csb_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  // 32-bit bus pins from the socket
  input  wire logic        card_bus_clock_in,
  input  wire logic        card_bus_reset_n_in,
  input  wire logic        cycle_frame_n_in,
  input  wire logic        initiator_ready_n_in,
  input  wire logic [3:0]  command_byte_enables_in,
  input  wire logic [31:0] addr_data_bus_in,
  input  wire logic        bus_parity_in,
  input  wire logic        clock_run_line_n_in,
  // 32-bit bus pins driven by the card
  output logic      [31:0] addr_data_bus_out,
  output logic             addr_data_bus_oe_out,
  output logic             bus_parity_out,
  output logic             bus_parity_oe_out,
  output logic             target_ready_n_out,
  output logic             target_ready_oe_out,
  output logic             device_select_n_out,
  output logic             device_select_oe_out,
  output logic             clock_run_line_n_out,
  output logic             clock_run_line_oe_out,
  output logic             card_bus_interrupt_n_out,
  output logic             status_change_line_out,
  output logic             card_audio_in_out,
  // 16-bit card pins
  input  wire logic        io_read_strobe_n_in,
  input  wire logic        io_write_strobe_n_in,
  input  wire logic        mem_read_strobe_n_in,
  input  wire logic        mem_write_strobe_n_in,
  input  wire logic [15:0] card_addr_in,
  output logic             card_irq_request_out,
  output logic             wait_n_out,
  output logic             wide_port_indication_n_out,
  // Card-internal user side
  input  wire logic        io_mode_in,
  input  wire logic        busy_in,
  input  wire logic        irq_req_in,
  input  wire logic        hold_in,
  input  wire logic        clk_fast_req_in,
  input  wire logic        audio_in,
  input  wire logic        status_event_in,
  output logic      [35:0] wr_data_out,
  output logic             wr_valid_out,
  input  wire logic        wr_ready_in,
  input  wire logic [31:0] rd_data_in,
  input  wire logic        rd_valid_in,
  output logic             rd_taken_out,
  output logic             parity_error_out,
  input  wire logic        parity_clear_in,
  output logic             clock_slowed_out
);
  // ========================================================================
  // Pin synchronisers
  logic [csb_pkg::SYNC_W-1:0] raw_pins;
  logic [csb_pkg::SYNC_W-1:0] sync_pins;
  logic        s_clk, s_rst_n, s_frame_n, s_irdy_n, s_par, s_clkrun_n;
  logic        s_io_read_strobe_n, s_io_write_strobe_n, s_oe_n, s_we_n;
  logic [3:0]  s_cbe;
  logic [31:0] s_ad;
  logic [15:0] s_addr16;

  // Everything from the socket is asynchronous to ref_clk_in
  assign raw_pins = {card_bus_clock_in, card_bus_reset_n_in, cycle_frame_n_in,
                     initiator_ready_n_in, bus_parity_in, clock_run_line_n_in,
                     io_read_strobe_n_in, io_write_strobe_n_in, mem_read_strobe_n_in,
                     mem_write_strobe_n_in, command_byte_enables_in, addr_data_bus_in,
                     card_addr_in};
  assign {s_clk, s_rst_n, s_frame_n, s_irdy_n, s_par, s_clkrun_n, s_io_read_strobe_n, s_io_write_strobe_n,
          s_oe_n, s_we_n, s_cbe, s_ad, s_addr16} = sync_pins;

  csb_sync #(.W(csb_pkg::SYNC_W), .RST_VAL(csb_pkg::SYNC_RST)) u_sync ( // [RQ25]
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (raw_pins),
    .sync_out   (sync_pins)
  );

  // ========================================================================
  // Write buffer
  csb_stream_if #(.W(csb_pkg::WORD_W)) push_if ();
  csb_stream_if #(.W(csb_pkg::WORD_W)) pop_if ();

  csb_fifo #(.W(csb_pkg::WORD_W), .DEPTH(DEPTH)) u_fifo (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .push_if    (push_if),
    .pop_if     (pop_if)
  );

  // The drain side stalls through wr_ready_in, which throttles target ready
  assign wr_data_out   = pop_if.data;
  assign wr_valid_out  = pop_if.valid;
  assign pop_if.ready  = wr_ready_in;

  // ========================================================================
  // Decode
  csb_pkg::csb_state_t state_q;
  logic        clk_seen_q;
  logic        frame_prev_q;
  logic        is_read_q;
  logic        trdy_n_q;
  logic        trdy_oe_q;
  logic        devsel_n_q;
  logic        devsel_oe_q;
  logic [31:0] ad_q;
  logic        ad_oe_q;
  logic        par_q;
  logic        par_oe_q;
  logic        push_valid_q;
  logic [35:0] push_data_q;
  logic        rd_taken_q;
  logic        chk_q;
  logic        exp_par_q;
  logic        perr_q;
  logic        link_tick;
  logic        addr_phase;
  logic        mem_hit;
  logic        io_hit;
  logic        claim;
  logic        cmd_read;
  logic        xfer;
  logic        last_xfer;
  logic        prep_read;
  logic        cycle16;
  logic        port16_hit;

  // Rising edge of the sampled card clock is the one-cycle bus enable
  assign link_tick  = s_clk & ~clk_seen_q; // [RQ15]
  // First clock with frame asserted after it was released
  assign addr_phase = link_tick & ~s_frame_n & frame_prev_q & (state_q == csb_pkg::ST_IDLE); // [RQ8]
  // Memory decode ignores the low two bits: a dword address
  assign mem_hit    = ((s_cbe == csb_pkg::CMD_MEM_RD) | (s_cbe == csb_pkg::CMD_MEM_WR))
                      & ((s_ad & MEM_MASK & 32'hFFFF_FFFC) == (MEM_BASE & 32'hFFFF_FFFC)); // [RQ8]
  assign io_hit     = ((s_cbe == csb_pkg::CMD_IO_RD) | (s_cbe == csb_pkg::CMD_IO_WR))
                      & ((s_ad & IO_MASK) == IO_BASE); // [RQ8]
  assign claim      = addr_phase & (mem_hit | io_hit); // [RQ11]
  assign cmd_read   = (s_cbe == csb_pkg::CMD_MEM_RD) | (s_cbe == csb_pkg::CMD_IO_RD);
  // A word moves only on a clock with both readies low
  assign xfer       = link_tick & (state_q == csb_pkg::ST_DATA) & ~trdy_n_q & ~s_irdy_n; // [RQ10]
  assign last_xfer  = xfer & s_frame_n; // [RQ21]
  assign prep_read  = link_tick & (state_q == csb_pkg::ST_DATA) & is_read_q & ~last_xfer
                      & (xfer | trdy_n_q) & rd_valid_in;
  assign cycle16    = ~s_io_read_strobe_n | ~s_io_write_strobe_n | ~s_oe_n | ~s_we_n;
  assign port16_hit = io_mode_in & WIDE_PORT & ((s_addr16 & IO16_MASK) == IO16_BASE);

  // ========================================================================
  // Clock edge finder
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      clk_seen_q   <= 1'b0;
      frame_prev_q <= 1'b1;
    end else begin
      clk_seen_q <= s_clk;
      if (link_tick) begin
        frame_prev_q <= s_frame_n;
      end
    end
  end

  // Target sequencer; a held bus reset drops every output enable at once
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !s_rst_n) begin // [RQ18]
      state_q     <= csb_pkg::ST_IDLE;
      is_read_q   <= 1'b0;
      trdy_n_q    <= 1'b1;
      trdy_oe_q   <= 1'b0;
      devsel_n_q  <= 1'b1;
      devsel_oe_q <= 1'b0;
    end else if (link_tick) begin
      unique case (state_q)
        csb_pkg::ST_IDLE: begin
          if (claim) begin
            state_q     <= csb_pkg::ST_DATA;
            is_read_q   <= cmd_read;
            devsel_n_q  <= 1'b0;
            devsel_oe_q <= 1'b1;
            trdy_oe_q   <= 1'b1;
            trdy_n_q    <= cmd_read | ~push_if.ready; // Read waits out the turnaround
          end else if (addr_phase) begin
            state_q <= csb_pkg::ST_SKIP;
          end
        end
        csb_pkg::ST_DATA: begin
          if (last_xfer) begin
            state_q    <= csb_pkg::ST_TURN; // [RQ21]
            trdy_n_q   <= 1'b1;
            devsel_n_q <= 1'b1;
          end else if (is_read_q) begin
            if (xfer | trdy_n_q) begin
              trdy_n_q <= ~rd_valid_in;
            end
          end else begin
            // One wait clock after each word keeps the buffer from overrunning
            trdy_n_q <= xfer | ~push_if.ready; // [RQ10]
          end
        end
        csb_pkg::ST_TURN: begin
          state_q     <= csb_pkg::ST_IDLE;
          trdy_oe_q   <= 1'b0;
          devsel_oe_q <= 1'b0;
        end
        csb_pkg::ST_SKIP: begin
          if (s_frame_n && s_irdy_n) begin
            state_q <= csb_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Read data drive and parity that trails it by one bus clock
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !s_rst_n) begin // [RQ18]
      ad_q       <= 32'h0000_0000;
      ad_oe_q    <= 1'b0;
      par_q      <= 1'b0;
      par_oe_q   <= 1'b0;
      rd_taken_q <= 1'b0;
    end else begin
      rd_taken_q <= prep_read;
      if (link_tick) begin
        par_q    <= ^{ad_q, s_cbe}; // [RQ12] [RQ13]
        par_oe_q <= ad_oe_q;        // [RQ14]
        ad_oe_q  <= (state_q == csb_pkg::ST_DATA) & is_read_q & ~last_xfer;
      end
      if (prep_read) begin
        ad_q <= rd_data_in; // [RQ9]
      end
    end
  end

  // Write capture into the buffer and parity check of what the initiator drove
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      push_valid_q <= 1'b0;
      push_data_q  <= 36'h0_0000_0000;
      chk_q        <= 1'b0;
      exp_par_q    <= 1'b0;
      perr_q       <= 1'b0;
    end else begin
      push_valid_q <= xfer & ~is_read_q;
      if (xfer) begin
        push_data_q <= {s_cbe, s_ad}; // [RQ9] [RQ11]
      end
      if (link_tick) begin
        chk_q     <= claim | (xfer & ~is_read_q); // [RQ14]
        exp_par_q <= ^{s_ad, s_cbe};
      end
      // A new error wins over a clear in the same cycle
      perr_q <= (link_tick & chk_q & (s_par != exp_par_q)) | (perr_q & ~parity_clear_in); // [RQ13]
    end
  end

  assign push_if.valid = push_valid_q;
  assign push_if.data  = push_data_q;

  // ========================================================================
  // Side-band lines
  logic irq16_q, wait_n_q, wide_n_q, clkrun_oe_q, slowed_q;
  logic card_bus_interrupt_n_q, stschg_q, audio_q;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      irq16_q     <= 1'b1;
      wait_n_q    <= 1'b1;
      wide_n_q    <= 1'b1;
      clkrun_oe_q <= 1'b0;
      slowed_q    <= 1'b0;
      card_bus_interrupt_n_q    <= 1'b1;
      stschg_q    <= 1'b0;
      audio_q     <= 1'b0;
    end else begin
      irq16_q     <= ~(io_mode_in ? irq_req_in : busy_in); // [RQ1] [RQ2]
      wait_n_q    <= ~(cycle16 & hold_in);                 // [RQ6]
      wide_n_q    <= ~port16_hit;                          // [RQ7]
      // Hold the pull once started, or the line would chatter as it falls
      clkrun_oe_q <= s_rst_n & clk_fast_req_in & (clkrun_oe_q | s_clkrun_n); // [RQ16]
      slowed_q    <= s_clkrun_n;                           // [RQ16]
      card_bus_interrupt_n_q    <= ~irq_req_in;
      stschg_q    <= status_event_in;
      audio_q     <= audio_in; // Binary level only; [RQ19]
    end
  end

  // ========================================================================
  // Output mapping
  assign addr_data_bus_out          = ad_q;
  assign addr_data_bus_oe_out       = ad_oe_q;
  assign bus_parity_out             = par_q;
  assign bus_parity_oe_out          = par_oe_q;
  assign target_ready_n_out         = trdy_n_q;
  assign target_ready_oe_out        = trdy_oe_q;
  assign device_select_n_out        = devsel_n_q;
  assign device_select_oe_out       = devsel_oe_q;
  assign clock_run_line_n_out       = 1'b0; // Open drain: only the enable moves
  assign clock_run_line_oe_out      = clkrun_oe_q;
  assign card_bus_interrupt_n_out   = card_bus_interrupt_n_q;
  assign status_change_line_out     = stschg_q;
  assign card_audio_in_out          = audio_q;
  assign card_irq_request_out       = irq16_q;
  assign wait_n_out                 = wait_n_q;
  assign wide_port_indication_n_out = wide_n_q;
  assign rd_taken_out               = rd_taken_q;
  assign parity_error_out           = perr_q;
  assign clock_slowed_out           = slowed_q;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence last_word_s;
    last_xfer;
  endsequence

  sequence release_s;
    (state_q == csb_pkg::ST_TURN) && devsel_n_q && trdy_n_q ##[1:12]
      (state_q == csb_pkg::ST_IDLE) && !devsel_oe_q && !trdy_oe_q;
  endsequence

  bus_reset_hiz_a: assert property ( // [RQ18]
    !s_rst_n |=> !ad_oe_q && !trdy_oe_q && !devsel_oe_q && !par_oe_q
  ) else $error("driver enabled during card bus reset");

  final_phase_a: assert property ( // [RQ21]
    last_word_s |=> release_s
  ) else $error("final data phase not followed by release");

  write_push_a: assert property ( // [RQ10]
    xfer && !is_read_q |=> push_valid_q && push_data_q == {$past(s_cbe), $past(s_ad)}
  ) else $error("write word not captured with its lanes");

  trdy_in_data_a: assert property ( // [RQ10]
    !trdy_n_q |-> state_q == csb_pkg::ST_DATA
  ) else $error("target ready asserted outside a data phase");

  addr_claim_a: assert property ( // [RQ8]
    claim |=> !devsel_n_q && devsel_oe_q && state_q == csb_pkg::ST_DATA
  ) else $error("decoded address not claimed");

  parity_lag_a: assert property ( // [RQ13]
    link_tick && s_rst_n |=> par_oe_q == $past(ad_oe_q) && par_q == ^{$past(ad_q), $past(s_cbe)}
  ) else $error("parity does not trail the bus by one clock");

  read_turn_a: assert property ( // [RQ14]
    claim && cmd_read |=> !ad_oe_q && !par_oe_q
  ) else $error("read data driven in the turnaround clock");

  wait_stretch_a: assert property ( // [RQ6]
    cycle16 && hold_in |=> !wait_n_q [*1] ##0 !wait_n_out
  ) else $error("wait not asserted while cycle held");

  ready_line_a: assert property ( // [RQ1]
    !io_mode_in && busy_in |=> !card_irq_request_out
  ) else $error("ready high while card busy");

  irq_line_a: assert property ( // [RQ2]
    io_mode_in && !irq_req_in |=> card_irq_request_out
  ) else $error("interrupt line low with no request");

  wide_port_a: assert property ( // [RQ7]
    !wide_port_indication_n_out |-> $past(port16_hit)
  ) else $error("wide port indicated for a foreign address");

  clock_run_a: assert property ( // [RQ16]
    clkrun_oe_q |-> $past(clk_fast_req_in)
  ) else $error("clock run pulled without a request");
endmodule : csb_card

// [verif/csb_host.sv]
/* Socket controller model: bus clock, reset release, parity.
   Assumes the bench drives the initiator lines. */
`timescale 1ns/1ps
// =====
// Host
module csb_host (
  // Clock and controls
  input  wire logic        ref_clk_in,
  input  wire logic        rel_in,
  input  wire logic        bad_par_in,
  input  wire logic [31:0] ad_in,
  input  wire logic [3:0]  cbe_in,
  // Driven lines
  output logic             bclk_out,
  output logic [2:0]       phase_out,
  output logic             rst_n_out = 1'b0,
  output logic             par_out = 1'b0
);
  logic [2:0] cnt_q = 3'h0;
  assign phase_out = cnt_q;
  assign bclk_out  = cnt_q[2];
  // Divide by eight; reset and parity move only as the clock falls
  always @(posedge ref_clk_in) begin
    cnt_q <= cnt_q + 3'h1;
    if (cnt_q == 3'h7) begin
      rst_n_out <= rel_in;
      par_out   <= ^{ad_in, cbe_in, bad_par_in};
    end
  end
endmodule : csb_host

// [verif/csb_card_bench.sv]
/* Bench for the card end of the socket bus.
   Assumes csb_host makes the bus clock, reset and parity. */
`timescale 1ns/1ps
// =====
// Bench
module csb_card_bench;
  logic        clk = 1'b0, rst = 1'b1, fr_n = 1'b1, ir_n = 1'b1, h_oe = 1'b0, ok, p;
  logic        rel = 1'b0, bad = 1'b0, wr_rdy = 1'b0, rd_v = 1'b0, pclr = 1'b0;
  logic [3:0]  cbe = 4'h0;
  logic [26:0] u = 27'h780;
  logic [31:0] h_ad = 32'h0, rd_d = 32'h0, seed = 32'h45, q, addr_data_bus_out;
  logic [35:0] wr_data_out, exp_q[$];
  logic        addr_data_bus_oe_out, bus_parity_out, target_ready_n_out, target_ready_oe_out;
  logic        clock_run_line_oe_out, card_audio_in_out, card_irq_request_out, wait_n_out;
  logic        wide_port_indication_n_out, wr_valid_out, parity_error_out, ds_n;
  int          err_count = 0, checks = 0;
  wire  [2:0]  ph;
  wire         bclk, brst_n, h_par;
  wire  [31:0] ad_w = h_oe ? h_ad : addr_data_bus_oe_out ? addr_data_bus_out : ~h_ad;
  wire  [3:0]  lines = {card_irq_request_out, card_audio_in_out, wait_n_out,
                        wide_port_indication_n_out};
  // Clock and system reset
  always #50 clk = ~clk;
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
  end
  csb_host h (.ref_clk_in(clk), .rel_in(rel), .bad_par_in(bad), .ad_in(ad_w), .cbe_in(cbe),
              .bclk_out(bclk), .phase_out(ph), .rst_n_out(brst_n), .par_out(h_par));
  csb_card dut (.ref_clk_in(clk), .sys_rst_in(rst), .card_bus_clock_in(bclk),
    .card_bus_reset_n_in(brst_n), .cycle_frame_n_in(fr_n), .initiator_ready_n_in(ir_n),
    .command_byte_enables_in(cbe), .addr_data_bus_in(ad_w), .bus_parity_in(h_par),
    .clock_run_line_n_in(~clock_run_line_oe_out), .addr_data_bus_out, .addr_data_bus_oe_out,
    .bus_parity_out, .bus_parity_oe_out(), .target_ready_n_out, .target_ready_oe_out,
    .device_select_n_out(ds_n), .device_select_oe_out(), .clock_run_line_n_out(),
    .clock_run_line_oe_out, .card_bus_interrupt_n_out(), .status_change_line_out(),
    .card_audio_in_out, .io_read_strobe_n_in(u[7]), .io_write_strobe_n_in(u[8]),
    .mem_read_strobe_n_in(u[9]), .mem_write_strobe_n_in(u[10]), .card_addr_in(u[26:11]),
    .card_irq_request_out, .wait_n_out, .wide_port_indication_n_out, .io_mode_in(u[0]),
    .busy_in(u[1]), .irq_req_in(u[2]), .hold_in(u[3]), .clk_fast_req_in(u[4]),
    .audio_in(u[5]), .status_event_in(u[6]), .wr_data_out, .wr_valid_out,
    .wr_ready_in(wr_rdy), .rd_data_in(rd_d), .rd_valid_in(rd_v), .rd_taken_out(),
    .parity_error_out, .parity_clear_in(pclr), .clock_slowed_out());
  task automatic chk(input logic [35:0] s, input logic [35:0] e, input string nm);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // Expected 16-bit card lines from the user levels
  function automatic logic [3:0] exp16(input logic [26:0] v);
    return {v[0] ? ~v[2] : ~v[1], v[5], ~(v[3] && v[10:7] != 4'hF),
            ~(v[0] && (v[26:11] & csb_pkg::IO16_MASK_DEF) == csb_pkg::IO16_BASE_DEF)};
  endfunction : exp16
  task automatic step(input logic [2:0] at);
    do @(posedge clk); while (ph != at);
  endtask : step
  // Single-phase cycle; lines change as the bus clock falls, trdy waits are bounded
  task automatic xfer(input logic [3:0] c, input logic [31:0] a, be_d);
    step(3'h7);
    {fr_n, cbe, h_ad, h_oe} <= {1'b0, c, a, 1'b1};
    step(3'h7);
    {fr_n, ir_n, cbe, h_ad, h_oe} <= {2'b10, be_d[3:0], be_d, c[0]};
    ok = 1'b0;
    for (int n = 0; n < 12 && ok !== 1'b1; n++) begin
      step(3'h3);
      ok = ~target_ready_n_out & target_ready_oe_out & ~ds_n;
    end
    q = ad_w;
    step(3'h7);
    {ir_n, h_oe} <= 2'b10;
    step(3'h3);
    p = bus_parity_out;
    step(3'h7);
  endtask : xfer
  initial begin
    repeat (12) @(posedge clk);
    chk({addr_data_bus_oe_out, target_ready_oe_out}, 36'h0, "oe in reset");
    rel <= 1'b1;
    repeat (40) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      xfer(i[0] ? csb_pkg::CMD_IO_WR : csb_pkg::CMD_MEM_WR, i[0] ? csb_pkg::IO_BASE_DEF +
           seed[3:0] : csb_pkg::MEM_BASE_DEF + seed[11:0], seed);
      chk(ok, 1'b1, "write ready");
      exp_q.push_back({seed[3:0], seed});
    end
    wr_rdy <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      if (wr_valid_out === 1'b1) chk(wr_data_out, exp_q.pop_front(), "fifo word");
    end
    chk({wr_valid_out, exp_q.size() == 0}, 2'b01, "drained");
    rd_v <= 1'b1;
    repeat (4) begin
      seed = xs(seed);
      rd_d <= seed;
      xfer(csb_pkg::CMD_MEM_RD, csb_pkg::MEM_BASE_DEF, {seed[31:4], 4'h0});
      chk(q, seed, "read data");
      chk(p, ^seed, "read parity");
    end
    bad <= 1'b1;
    xfer(csb_pkg::CMD_MEM_WR, csb_pkg::MEM_BASE_DEF, seed);
    bad <= 1'b0;
    repeat (12) @(posedge clk);
    chk(parity_error_out, 1'b1, "parity flag");
    pclr <= 1'b1;
    repeat (3) @(posedge clk);
    chk(parity_error_out, 1'b0, "parity clear");
    repeat (24) begin
      seed = xs(seed);
      u <= {seed[20] ? {12'h030, seed[24:21]} : seed[31:16], seed[10:0]};
      repeat (8) @(posedge clk);
      chk(lines, exp16(u), "card lines");
    end
    tally_and_finish;
  end
  // Watchdog far past the run
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish;
  end
endmodule : csb_card_bench
